// >>> core_seq_model.sv
// Purpose: core sequencer stand-in that takes offered events
// Assumes: same clock as the controller
// Notes: takes an offer after it has stood i_lat cycles
`timescale 1ns/1ps
module core_seq_model (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_en,
	input wire logic [3:0] i_lat,
	input wire logic i_req,
	output logic o_accept
);
	logic [3:0] age_q;
	// ==========
	// offer age
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			age_q <= 4'h0;
		else if (!i_req || o_accept)
			age_q <= 4'h0;
		else if (age_q != 4'hf)
			age_q <= age_q + 4'h1;
	end
	// only taken while still offered, so an outranked offer is never grabbed
	assign o_accept = i_en && i_req && age_q >= i_lat;
endmodule : core_seq_model

// >>> evt_checker.sv
// Purpose: port-level assertions for the event controller
// Assumes: one clock, asynchronous active-low reset
// Notes: bound onto evt_ctrl_top below
`timescale 1ns/1ps
module evt_checker
	import evt_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic [2:0] i_pprot,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_align_err,
	input wire logic i_undef_instr,
	input wire logic i_accept,
	input wire logic i_return,
	input wire logic i_core_idle,
	input wire logic o_service_req,
	input wire logic [3:0] o_service_level,
	input wire logic o_exception_now,
	input wire logic [NUM_LEVELS-1:0] o_event_active,
	input wire logic o_wake
);
	// ==========
	// assertions
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	apb_answer_a: assert property (i_psel && i_penable && !o_pready |=> o_pready)
		else $error("access not answered one cycle later");
	priv_refuse_a: assert property (i_psel && i_penable && !o_pready && !i_pprot[0] |=> o_pslverr)
		else $error("user access not refused");
	refused_data_a: assert property (o_pready && o_pslverr |-> o_prdata == 32'h0)
		else $error("refused access returned data");
	exc_pulse_a: assert property (i_align_err || i_undef_instr |=> o_exception_now)
		else $error("exception not taken at once");
	exc_cause_a: assert property ($rose(o_exception_now) |-> $past(i_align_err || i_undef_instr))
		else $error("exception without a cause");
	accept_set_a: assert property (i_accept && o_service_req && !i_return
		|=> o_event_active[$past(o_service_level)])
		else $error("accepted level not active");
	active_cause_a: assert property ((o_event_active & ~$past(o_event_active)) != 16'h0
		|-> $past(i_accept && o_service_req))
		else $error("active bit set without acceptance");
	offer_rank_a: assert property (o_service_req
		|-> (o_event_active & ((16'h2 << o_service_level) - 16'h1)) == 16'h0)
		else $error("offer not more urgent than active events");
	wake_idle_a: assert property (o_wake |-> $past(i_core_idle))
		else $error("wake while core not idle");
endmodule : evt_checker

bind evt_ctrl_top evt_checker u_evt_checker (.i_clk, .i_rstn, .i_psel, .i_penable, .i_pprot, .o_prdata,
	.o_pready, .o_pslverr, .i_align_err, .i_undef_instr, .i_accept, .i_return, .i_core_idle,
	.o_service_req, .o_service_level, .o_exception_now, .o_event_active, .o_wake);

// >>> evt_ctrl_top.sv
// Purpose: two-stage event controller, core stage plus system router
// Assumes: APB slave, i_pprot[0] marks a supervisor access, core sequencer on i_clk
// Notes: service request is offered to the core and taken by i_accept
//
// Overview of operation
// R1: sixteen levels, 0 most urgent: emu, reset, nmi, exception, reserved, hwerr, tick, general.
// R2: nine general inputs occupy levels 7 through 15.
// R3: software should keep levels 14 and 15 for software-raised handlers.
// R4: nesting allowed; a more urgent event always preempts a less urgent one.
// R5: router sends each peripheral source to a general level, software reassignable.
// R6: reset assignment follows the default source-to-level table.
// R7: rising edge on a general input sets its latch bit; detection takes two cycles; here three from the pin, through the synchroniser and router register.
// R8: latch bit clears when its active bit sets.
// R9: after the active bit sets, the next rising edge is queued again.
// R10: at least three cycles from input edge to active bit.
// R11: latch self-updates; supervisor writes cancel only bits whose mask is clear.
// R12: set mask bit allows servicing; clear bit blocks it while latched.
// R13: global on/off instructions gate all general levels regardless of mask.
// R14: active register tracks nested events, controller-updated, supervisor readable.
// R15: router mask passes a source when set, blocks it when clear.
// R16: router status shows each source currently asserting.
// R17: enabled wake bits let a source event wake an idle core.
// R18: router treats the core active bits as acknowledgement.
// R19: router mask, status and wake registers are 32 bits, one bit per source.
// R20: nmi raised by watchdog or by the external nmi pin.
// R21: exceptions from alignment or undefined instruction are taken synchronously.
// R22: control registers reachable only in supervisor mode.
// R23: unmasked sources sharing a level are ORed into that level.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
module evt_ctrl_top
	import evt_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [2:0] i_pprot,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// pins
	input wire logic [NUM_SRC-1:0] i_periph_irq,
	input wire logic i_nmi_pin,
	input wire logic i_wdog_nmi,
	input wire logic i_emu_req,
	// core side, same clock
	input wire logic i_align_err,
	input wire logic i_undef_instr,
	input wire logic i_hw_err,
	input wire logic i_core_tick,
	input wire logic i_global_irq_on_instr,
	input wire logic i_global_irq_off_instr,
	input wire logic i_supervisor,
	input wire logic i_accept,
	input wire logic i_return,
	input wire logic i_core_idle,
	output logic o_service_req,
	output logic [3:0] o_service_level,
	output logic o_exception_now,
	output logic [NUM_LEVELS-1:0] o_event_active,
	output logic o_wake
);
	// ==========================================================
	// helpers
	// lowest set index wins; NUM_LEVELS means none set
	function automatic logic [4:0] first_set(input logic [NUM_LEVELS-1:0] v);
		logic [4:0] idx;
		idx = 5'(NUM_LEVELS);
		for (int i = NUM_LEVELS - 1; i >= 0; i--)
			if (v[i])
				idx = 5'(i);
		return idx;
	endfunction : first_set

	// ==========================================================
	// input synchronisers
	logic [NUM_SRC-1:0] src_sync;
	logic [2:0] misc_sync;
	logic [1:0] pin_prev_q;

	sync2 #(.W(NUM_SRC)) u_src_sync (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_d(i_periph_irq),
		.o_q(src_sync)
	);

	sync2 #(.W(3)) u_misc_sync (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_d({i_emu_req, i_wdog_nmi, i_nmi_pin}),
		.o_q(misc_sync)
	);

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			pin_prev_q <= '0;
		else
			pin_prev_q <= {misc_sync[2], misc_sync[1] | misc_sync[0]};
	end

	// ==========================================================
	// register state
	logic [NUM_LEVELS-1:0] latch_q;
	logic [NUM_LEVELS-1:0] latch_d;
	logic [NUM_LEVELS-1:0] mask_q;
	logic [NUM_LEVELS-1:0] active_q;
	logic [NUM_LEVELS-1:0] active_d;
	logic [NUM_SRC-1:0] rmask_q;
	logic [NUM_SRC-1:0] rwake_q;
	logic [31:0] assign_q [3];
	logic gie_q;
	logic [NUM_GEN-1:0] gen_prev_q;

	// ==========================================================
	// router
	router_if #(.NSRC(NUM_SRC), .NGEN(NUM_GEN), .AW(ASSIGN_W)) rt ();

	assign rt.src = src_sync;
	assign rt.mask = rmask_q;
	assign rt.assign_map = {assign_q[2][NUM_SRC*ASSIGN_W-65:0], assign_q[1], assign_q[0]};
	assign rt.ack = active_q[NUM_LEVELS-1:GEN_BASE];

	irq_router u_router (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.bus(rt)
	);

	// ==========================================================
	// apb decode
	logic acc;
	logic wr;
	logic priv;
	logic hit;
	logic [31:0] rdata;

	assign acc = i_psel && i_penable && !o_pready;
	assign priv = i_pprot[0];
	assign wr = acc && i_pwrite && priv && hit; // R22

	always_comb
	begin
		hit = 1'b1;
		rdata = '0;
		case (i_paddr)
			OFS_LATCH: rdata = 32'(latch_q);
			OFS_MASK: rdata = 32'(mask_q);
			OFS_ACTIVE: rdata = 32'(active_q); // R14
			OFS_RMASK: rdata = 32'(rmask_q);
			OFS_RSTAT: rdata = 32'(rt.status); // R16 R19
			OFS_RWAKE: rdata = 32'(rwake_q);
			OFS_CTRL: rdata = 32'(gie_q) | (32'(rt.owed) << CTRL_OWED_LSB);
			OFS_RAISE: rdata = '0;
			OFS_ASSIGN0: rdata = assign_q[0];
			OFS_ASSIGN1: rdata = assign_q[1];
			OFS_ASSIGN2: rdata = assign_q[2];
			default: hit = 1'b0;
		endcase
	end

	// one wait state: answer on the second access cycle
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= '0;
		end
		else
		begin
			o_pready <= acc;
			o_pslverr <= acc && (!hit || !priv); // R22
			o_prdata <= (acc && hit && priv && !i_pwrite) ? rdata : '0;
		end
	end

	// ==========================================================
	// configuration registers
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			mask_q <= MASK_RESET;
		else if (wr && i_paddr == OFS_MASK)
			mask_q <= (i_pwdata[NUM_LEVELS-1:0] & MASK_WRITABLE) | FIXED_MASK; // R12
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rmask_q <= RMASK_RESET[NUM_SRC-1:0];
			rwake_q <= RWAKE_RESET[NUM_SRC-1:0];
		end
		else if (wr)
		begin
			if (i_paddr == OFS_RMASK)
				rmask_q <= i_pwdata[NUM_SRC-1:0]; // R15 R19
			if (i_paddr == OFS_RWAKE)
				rwake_q <= i_pwdata[NUM_SRC-1:0]; // R17 R19
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			assign_q[0] <= ASSIGN0_RESET; // R6
			assign_q[1] <= ASSIGN1_RESET; // R6
			assign_q[2] <= ASSIGN2_RESET; // R6
		end
		else if (wr)
		begin
			if (i_paddr == OFS_ASSIGN0)
				assign_q[0] <= i_pwdata; // R5
			if (i_paddr == OFS_ASSIGN1)
				assign_q[1] <= i_pwdata; // R5
			if (i_paddr == OFS_ASSIGN2)
				assign_q[2] <= i_pwdata; // R5
		end
	end

	// instructions take priority over a register write in the same cycle
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			gie_q <= 1'b0;
		else if (i_global_irq_off_instr)
			gie_q <= 1'b0; // R13
		else if (i_global_irq_on_instr)
			gie_q <= 1'b1; // R13
		else if (wr && i_paddr == OFS_CTRL)
			gie_q <= i_pwdata[CTRL_GIE_BIT];
	end

	// ==========================================================
	// event latch
	logic [NUM_LEVELS-1:0] set_ev;
	logic [NUM_GEN-1:0] gen_rise;
	logic exc_ev;

	assign exc_ev = i_align_err || i_undef_instr; // R21
	// edge after synchroniser and router register: three cycles of detection before the latch
	assign gen_rise = rt.level & ~gen_prev_q; // R7 R9

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			gen_prev_q <= '0;
		else
			gen_prev_q <= rt.level;
	end

	always_comb
	begin
		set_ev = '0;
		set_ev[LVL_EMU] = misc_sync[2] && !pin_prev_q[1];
		set_ev[LVL_NMI] = (misc_sync[1] | misc_sync[0]) && !pin_prev_q[0]; // R20
		set_ev[LVL_EXC] = exc_ev; // R21
		set_ev[LVL_HWE] = i_hw_err;
		set_ev[LVL_TICK] = i_core_tick;
		set_ev[NUM_LEVELS-1:GEN_BASE] = gen_rise; // R2 R7
		if (wr && i_paddr == OFS_RAISE)
			set_ev[NUM_LEVELS-1:GEN_BASE] = gen_rise | i_pwdata[NUM_LEVELS-1:GEN_BASE]; // R3
	end

	always_comb
	begin
		latch_d = latch_q;
		if (wr && i_paddr == OFS_LATCH && i_supervisor)
			latch_d = latch_d & ~(i_pwdata[NUM_LEVELS-1:0] & ~mask_q); // R11
		latch_d = latch_d & ~(active_d & ~active_q); // R8
		latch_d = latch_d | set_ev; // R9
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			latch_q <= LATCH_RESET;
		else
			latch_q <= latch_d; // R11
	end

	// ==========================================================
	// prioritisation and nesting
	logic [NUM_LEVELS-1:0] eff_mask;
	logic [NUM_LEVELS-1:0] ready;
	logic [4:0] best;
	logic [4:0] cur;

	always_comb
	begin
		eff_mask = mask_q | FIXED_MASK;
		if (!gie_q)
			eff_mask[NUM_LEVELS-1:GEN_BASE] = '0; // R13
	end

	assign ready = latch_q & eff_mask; // R12
	assign best = first_set(ready); // R1
	assign cur = first_set(active_q);

	// offer only a level more urgent than everything in service
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_service_req <= 1'b0;
			o_service_level <= '0;
			o_exception_now <= 1'b0;
		end
		else
		begin
			o_service_req <= (best < cur) && !(i_accept && o_service_req); // R4
			o_service_level <= best[3:0]; // R1
			o_exception_now <= exc_ev; // R21
		end
	end

	// ==========================================================
	// active register
	always_comb
	begin
		active_d = active_q;
		if (i_return && cur < 5'(NUM_LEVELS))
			active_d[cur[3:0]] = 1'b0;
		if (i_accept && o_service_req && ready[o_service_level])
			active_d[o_service_level] = 1'b1; // R10 R14
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			active_q <= '0;
		else
			active_q <= active_d; // R14
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_event_active <= '0;
		else
			o_event_active <= active_d;
	end

	// ==========================================================
	// wakeup
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_wake <= 1'b0;
		else
			o_wake <= i_core_idle && |(src_sync & rwake_q); // R17
	end
endmodule : evt_ctrl_top

// >>> evt_pkg.sv
// Purpose: shared constants for the two-stage event controller
// Assumes: 16 core event levels, 24 peripheral sources, APB register port
// Notes: assignment fields hold (general level - 7), 4 bits per source
package evt_pkg;
	// ==========================================================
	// sizes
	localparam int NUM_LEVELS = 16;
	localparam int NUM_SRC = 24;
	localparam int NUM_GEN = 9;
	localparam int GEN_BASE = 7;
	localparam int ASSIGN_W = 4;
	localparam int SRC_PER_REG = 8;
	localparam int SYNC_STAGES = 2;
	// ==========================================================
	// event levels, 0 most urgent
	localparam int LVL_EMU = 0;
	localparam int LVL_RST = 1;
	localparam int LVL_NMI = 2;
	localparam int LVL_EXC = 3;
	localparam int LVL_HWE = 5;
	localparam int LVL_TICK = 6;
	localparam logic [15:0] FIXED_MASK = 16'h000f;
	localparam logic [15:0] MASK_WRITABLE = 16'hffe0;
	localparam logic [15:0] MASK_RESET = 16'h000f;
	localparam logic [15:0] LATCH_RESET = 16'h0002;
	// ==========================================================
	// register byte offsets
	localparam logic [11:0] OFS_LATCH = 12'h000;
	localparam logic [11:0] OFS_MASK = 12'h004;
	localparam logic [11:0] OFS_ACTIVE = 12'h008;
	localparam logic [11:0] OFS_RMASK = 12'h00c;
	localparam logic [11:0] OFS_RSTAT = 12'h010;
	localparam logic [11:0] OFS_RWAKE = 12'h014;
	localparam logic [11:0] OFS_CTRL = 12'h018;
	localparam logic [11:0] OFS_RAISE = 12'h01c;
	localparam logic [11:0] OFS_ASSIGN0 = 12'h020;
	localparam logic [11:0] OFS_ASSIGN1 = 12'h024;
	localparam logic [11:0] OFS_ASSIGN2 = 12'h028;
	// ==========================================================
	// reset values
	localparam logic [31:0] ASSIGN0_RESET = 32'h10000000;
	localparam logic [31:0] ASSIGN1_RESET = 32'h33322221;
	localparam logic [31:0] ASSIGN2_RESET = 32'h66655444;
	localparam logic [31:0] RMASK_RESET = 32'h00000000;
	localparam logic [31:0] RWAKE_RESET = 32'h00000000;
	localparam int CTRL_GIE_BIT = 0;
	localparam int CTRL_OWED_LSB = 16;
endpackage : evt_pkg

// >>> irq_router.sv
// Purpose: maps peripheral sources onto the general core levels
// Assumes: sources already synchronised
// Notes: a level is the OR of its unmasked sources
`timescale 1ns/1ps
module irq_router
	import evt_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	router_if.router bus
);
	logic [NUM_GEN-1:0] level_d;
	logic [NUM_GEN-1:0] level_q;
	logic [NUM_SRC-1:0] status_q;
	logic [NUM_GEN-1:0] owed_q;
	always_comb
	begin
		level_d = '0;
		for (int s = 0; s < NUM_SRC; s++)
			for (int g = 0; g < NUM_GEN; g++)
				if (bus.assign_map[s*ASSIGN_W +: ASSIGN_W] == ASSIGN_W'(g) && bus.src[s] && bus.mask[s]) // R5 R15 R23
					level_d[g] = 1'b1;
	end
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			level_q <= '0;
		else
			level_q <= level_d;
	end
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			status_q <= '0;
		else
			status_q <= bus.src; // R16
	end
	// a level stays owed from its rising edge until the core shows it active
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			owed_q <= '0;
		else
			owed_q <= (owed_q & ~bus.ack) | (level_d & ~level_q); // R18
	end
	assign bus.level = level_q;
	assign bus.status = status_q;
	assign bus.owed = owed_q;
endmodule : irq_router

// >>> router_if.sv
// Purpose: carrier between the core controller and the system router
// Assumes: single clock domain
// Notes: ack carries the active bits of the general levels
`timescale 1ns/1ps
interface router_if #(
	parameter int NSRC = 24,
	parameter int NGEN = 9,
	parameter int AW = 4
);
	logic [NSRC-1:0] src;
	logic [NSRC-1:0] mask;
	logic [NSRC-1:0] status;
	logic [NSRC*AW-1:0] assign_map;
	logic [NGEN-1:0] level;
	logic [NGEN-1:0] ack;
	logic [NGEN-1:0] owed;
	modport router (input src, mask, assign_map, ack, output status, level, owed);
	modport ctrl (output src, mask, assign_map, ack, input status, level, owed);
endinterface : router_if

// >>> sync2.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs asynchronous to i_clk
// Notes: only the second stage may be read
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= i_d;
			sync_q <= meta_q;
		end
	end
	assign o_q = sync_q;
endmodule : sync2

// >>> test_two_stage_event_controller.sv
// Purpose: self-checking bench for the event controller
// Assumes: APB master here, core sequencer in core_seq_model
// Notes: every APB answer is compared against a queued note
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_total++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module test_two_stage_event_controller
	import evt_pkg::*;
;
	logic i_clk, i_rstn, psel, pen, pwr, gon, goff, ret, idle, acc, req, excn, wake, pready, pslverr, sup;
	logic [11:0] padr;
	logic [31:0] pwd, prdata, r;
	logic [2:0] prot;
	logic [NUM_SRC-1:0] irq;
	logic [6:0] ev;
	logic [3:0] lat, lvl;
	logic [15:0] act;
	logic [32:0] q[$];
	logic [32:0] note;
	int err_total, check_count, n, k;
	int lv[7] = '{0, 2, 2, 3, 3, 5, 6};
	logic [11:0] ra[8] = '{OFS_MASK, OFS_RMASK, OFS_RWAKE, OFS_CTRL, OFS_ASSIGN0, OFS_ASSIGN1, OFS_ASSIGN2,
		OFS_ACTIVE};
	logic [31:0] rv[8] = '{32'hf, 32'h0, 32'h0, 32'h0, 32'h10000000, 32'h33322221, 32'h66655444, 32'h0};

	evt_ctrl_top u_evt_ctrl_top (.i_clk, .i_rstn, .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(padr), .i_pwdata(pwd), .i_pprot(prot), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_periph_irq(irq), .i_emu_req(ev[0]), .i_nmi_pin(ev[1]), .i_wdog_nmi(ev[2]),
		.i_align_err(ev[3]), .i_undef_instr(ev[4]), .i_hw_err(ev[5]), .i_core_tick(ev[6]),
		.i_global_irq_on_instr(gon), .i_global_irq_off_instr(goff), .i_supervisor(sup), .i_accept(acc),
		.i_return(ret), .i_core_idle(idle), .o_service_req(req), .o_service_level(lvl),
		.o_exception_now(excn), .o_event_active(act), .o_wake(wake));
	core_seq_model u_core_seq_model (.i_clk, .i_rstn, .i_en(1'b1), .i_lat(lat), .i_req(req), .o_accept(acc));

	initial
	begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end

	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nxt

	task complete_run;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	// ==========
	// bus cycles
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
		int m;
		q.push_back(x);
		@(posedge i_clk);
		psel <= 1'b1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge i_clk);
		pen <= 1'b1;
		for (m = 0; m < 20 && pready !== 1'b1; m++) @(posedge i_clk);
		psel <= 1'b0;
		pen <= 1'b0;
		if (m >= 20)
		begin
			err_total++;
			complete_run;
		end
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, {1'b0, x});
	endtask : rd

	task do_ret;
		ret <= 1'b1;
		@(posedge i_clk);
		ret <= 1'b0;
		@(posedge i_clk);
	endtask : do_ret

	task wait_act(input int l, input logic [15:0] x, input logic rt);
		for (n = 0; n < 60 && act[l] !== 1'b1; n++) @(posedge i_clk);
		`CHK(act, x)
		if (n >= 60)
			complete_run;
		if (rt)
			do_ret;
	endtask : wait_act

	always @(posedge i_clk)
	begin
		if (i_rstn && pready === 1'b1)
		begin
			// pop once: the macro names its expected value twice
			note = q.size() ? q.pop_front() : 33'h1deadbeef;
			`CHK({pslverr, prdata}, note)
		end
	end

	// ==========
	// main sequence
	initial
	begin
		{i_rstn, psel, pen, pwr, gon, goff, ret, idle} = 8'h0;
		{padr, pwd, irq, ev, lat} = 0;
		prot = 3'b001;
		sup = 1'b1;
		repeat (6) @(posedge i_clk);
		i_rstn <= 1'b1;
		wait_act(1, 16'h0002, 1'b1);
		for (k = 0; k < 8; k++) rd(ra[k], rv[k]);
		apb(1'b0, 12'h0fc, 32'h0, {1'b1, 32'h0});
		prot <= 3'b000;
		apb(1'b0, OFS_MASK, 32'h0, {1'b1, 32'h0});
		prot <= 3'b001;
		r = 32'h00007b5e;
		for (k = 0; k < 3; k++)
		begin
			r = nxt(nxt(r));
			wr(OFS_RWAKE, r);
			rd(OFS_RWAKE, {8'h0, r[23:0]});
			irq <= r[23:0];
			repeat (4) @(posedge i_clk);
			rd(OFS_RSTAT, {8'h0, r[23:0]});
		end
		wr(OFS_ASSIGN0, r);
		rd(OFS_ASSIGN0, r);
		wr(OFS_ASSIGN2, ~r);
		rd(OFS_ASSIGN2, ~r);
		irq <= '0;
		wr(OFS_RWAKE, 32'h0);
		wr(OFS_MASK, 32'hffffffff);
		rd(OFS_MASK, 32'h0000ffef);
		wr(OFS_RMASK, 32'h00000600);
		gon <= 1'b1;
		@(posedge i_clk);
		gon <= 1'b0;
		lat <= 4'h5;
		irq[10] <= 1'b1;
		wait_act(9, 16'h0200, 1'b0);
		`CHK(n >= 3, 1'b1)
		rd(OFS_RSTAT, 32'h00000400);
		rd(OFS_LATCH, 32'h0);
		irq[10] <= 1'b0;
		repeat (4) @(posedge i_clk);
		irq[9] <= 1'b1;
		repeat (6) @(posedge i_clk);
		rd(OFS_LATCH, 32'h00000200);
		do_ret;
		wait_act(9, 16'h0200, 1'b1);
		irq <= '0;
		wr(OFS_RAISE, 32'h00000200);
		wait_act(9, 16'h0200, 1'b0);
		wr(OFS_MASK, 32'h0000ff7f);
		wr(OFS_RAISE, 32'h00000080);
		repeat (4) @(posedge i_clk);
		`CHK(req, 1'b0)
		rd(OFS_LATCH, 32'h00000080);
		sup <= 1'b0;
		wr(OFS_LATCH, 32'h00000080);
		rd(OFS_LATCH, 32'h00000080);
		sup <= 1'b1;
		wr(OFS_LATCH, 32'h00000080);
		rd(OFS_LATCH, 32'h0);
		wr(OFS_RAISE, 32'h00000080);
		wr(OFS_MASK, 32'h0000ffff);
		wait_act(7, 16'h0280, 1'b1);
		`CHK(act, 16'h0200)
		do_ret;
		goff <= 1'b1;
		@(posedge i_clk);
		goff <= 1'b0;
		wr(OFS_RAISE, 32'h00000100);
		irq[10] <= 1'b1;
		repeat (4) @(posedge i_clk);
		`CHK(req, 1'b0)
		// level 9 delivered by the router but held back by the global gate
		rd(OFS_CTRL, 32'h00040000);
		irq <= '0;
		gon <= 1'b1;
		@(posedge i_clk);
		gon <= 1'b0;
		wait_act(8, 16'h0100, 1'b1);
		wait_act(9, 16'h0200, 1'b1);
		rd(OFS_CTRL, 32'h00000001);
		// source 9 moved to level 12, clear of the software-only levels
		wr(OFS_ASSIGN1, 32'h33322251);
		lat <= 4'h0;
		irq[9] <= 1'b1;
		wait_act(12, 16'h1000, 1'b1);
		irq <= '0;
		for (k = 0; k < 7; k++)
		begin
			ev <= 7'(1 << k);
			@(posedge i_clk);
			ev <= 7'h0;
			wait_act(lv[k], 16'h1 << lv[k], 1'b1);
		end
		wr(OFS_CTRL, 32'h00000000);
		rd(OFS_CTRL, 32'h00000000);
		wr(OFS_RWAKE, 32'h00000020);
		idle <= 1'b1;
		irq[5] <= 1'b1;
		for (n = 0; n < 20 && wake !== 1'b1; n++) @(posedge i_clk);
		`CHK(wake, 1'b1)
		complete_run;
	end
endmodule : test_two_stage_event_controller
